//--- testbench/sfr_bank_monitor.sv
// Checker: bus answer timing, reset loads and guarded writes of the register bank
`timescale 1ns/1ps
`default_nettype none
module sfr_bank_monitor
  import sfr_bank_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        srst,
  input wire logic        por,
  input wire logic [7:0]  config_word_two,
  input wire logic        config_watchdog_bit,
  input wire logic [7:0]  config_flash_start_byte,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  power_out,
  input wire logic [7:0]  chip_out,
  input wire logic [7:0]  flash_start_out,
  input wire logic        brownout_enable,
  input wire logic        brownout_flag,
  input wire logic        watchdog_enable_bit,
  input wire logic        timed_access
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////////
  // Values seen just before a reset; a warm reset must hand them back
  logic [11:0] keep_q;
  always_ff @(posedge clk_sys) begin
    if (!srst) begin
      keep_q <= {flash_start_out, watchdog_enable_bit, brownout_enable, brownout_flag, power_out[4]};
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write) ##1 avs_waitrequest)
    else $error("answer not a single cycle after a request");
  ack_time_a: assert property (($rose(avs_read) || $rose(avs_write)) |=> !avs_waitrequest)
    else $error("request not answered in the next cycle");
  unmapped_rd_a: assert property (!avs_waitrequest && avs_read && avs_address[9] |-> avs_readdata == 32'h0)
    else $error("unmapped read not fixed");
  upper_zero_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  por_power_a: assert property ($fell(srst) && $past(por) |-> power_out == RST_POWER_POR)
    else $error("power control wrong after power-on");
  warm_power_a: assert property ($fell(srst) && !$past(por) |-> (power_out & 8'hEF) == 8'h00)
    else $error("power control wrong after warm reset");
  por_load_a: assert property ($fell(srst) && $past(por) |->
      flash_start_out == $past(config_flash_start_byte) && watchdog_enable_bit == !$past(config_watchdog_bit)
      && brownout_enable == $past(config_word_two[7]))
    else $error("configuration not loaded at power-on");
  por_flag_a: assert property ($fell(srst) && $past(por) && $past(config_word_two[7]) |-> brownout_flag)
    else $error("brownout flag not set at power-on");
  warm_keep_a: assert property ($fell(srst) && !$past(por) |-> keep_q ==
      {flash_start_out, watchdog_enable_bit, brownout_enable, brownout_flag, power_out[4]})
    else $error("kept bits changed by warm reset");
  chip_guard_a: assert property ($changed(chip_out) |-> $past(timed_access) || $past(srst))
    else $error("chip control written without timed access");
  flash_guard_a: assert property ($changed(flash_start_out) |-> $past(timed_access) || $past(srst))
    else $error("flash start written without timed access");
endmodule // sfr_bank_monitor
bind sfr_bank sfr_bank_monitor sfr_bank_monitor_i (.clk_sys, .srst, .por, .config_word_two, .config_watchdog_bit,
  .config_flash_start_byte, .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .power_out,
  .chip_out, .flash_start_out, .brownout_enable, .brownout_flag, .watchdog_enable_bit, .timed_access);
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for the register bank: reset loads, map sweep, bit space, guarded writes
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sfr_bank_pkg::*;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        por = 1'b1;
  logic [7:0]  config_word_two = 8'h90;         // Brownout on at first power-on
  logic        config_watchdog_bit = 1'b0;
  logic        config_boot_bit = 1'b0;
  logic [7:0]  config_flash_start_byte = 8'h3C;
  logic [9:0]  avs_address = 10'h000;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [7:0]  port0_out, power_out, chip_out, flash_start_out;
  logic        brownout_enable, brownout_flag, watchdog_enable_bit, timed_access;
  int          mismatches = 0;
  int          checked = 0;
  logic [7:0]  bases [3] = '{BIT_BASE_PORT0, BIT_BASE_TCTL, BIT_BASE_SCTL};
  sfr_bank sfr_bank_i (.clk_sys, .srst, .por, .config_word_two, .config_watchdog_bit, .config_boot_bit,
    .config_flash_start_byte, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .port0_out, .power_out, .chip_out, .flash_start_out, .brownout_enable,
    .brownout_flag, .watchdog_enable_bit, .timed_access);
  initial forever #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////////
  // Expected {reset value, writable mask} of an offset
  function automatic logic [15:0] spec(input logic [7:0] o);
    case (o)
      OFS_PORT1:     spec = {RST_PORT, MASK_PORT1};
      OFS_PORT0:     spec = {RST_PORT, 8'hFF};
      OFS_STACK:     spec = {RST_STACK, 8'hFF};
      OFS_POWER:     spec = {RST_POWER_POR, MASK_POWER};
      OFS_TCLK_SEL:  spec = {RST_ZERO, MASK_TCLK};
      OFS_CAP_EN:    spec = {RST_ZERO, MASK_CAP_EN};
      OFS_CAP_EDGE:  spec = {RST_ZERO, MASK_CAP_EDGE};
      OFS_CAP_FILT:  spec = {RST_ZERO, MASK_CAP_FILT};
      OFS_P3_MODE_B: spec = {RST_ZERO, MASK_P3_B};
      default:       spec = {RST_ZERO, 8'hFF};
    endcase
  endfunction
  // Plain registers of the sweep; holes read as fixed value
  function automatic logic mapped(input logic [7:0] o);
    mapped = o inside {[8'h80:8'h83], 8'h87, [8'h88:8'h8E], 8'h90, [8'h92:8'h99]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // One Avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be,
                     output logic [7:0] q);
    int n;
    n = 0;
    avs_address    <= a;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    avs_write      <= wr;
    avs_read       <= ~wr;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0 && n < 40) begin
      n++;
      @(posedge clk_sys);
    end
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n == 40) begin
      mismatches++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
      summarize();
    end else begin
      @(posedge clk_sys);
    end
  endtask
  task automatic unlock;
    logic [7:0] q;
    bus(1'b1, 10'(OFS_TA_UNLOCK), TA_KEY_FIRST, 4'h1, q);
    bus(1'b1, 10'(OFS_TA_UNLOCK), TA_KEY_SECOND, 4'h1, q);
  endtask
  // Synchronous reset; por marks a power-on reset
  task automatic do_reset(input logic p, input int n);
    srst <= 1'b1;
    por  <= p;
    repeat (n) @(posedge clk_sys);
    srst <= 1'b0;
    por  <= 1'b0;
    @(posedge clk_sys);
  endtask
  // Whole map after power-on, against the current configuration inputs
  task automatic chk_por;
    logic [7:0] q;
    chk(power_out, RST_POWER_POR);
    chk(flash_start_out, config_flash_start_byte);
    chk(watchdog_enable_bit, {7'h0, ~config_watchdog_bit});
    chk(brownout_enable, config_word_two[7]);
    if (config_word_two[7] === 1'b1) begin
      chk(brownout_flag, 1'b1);
    end
    bus(1'b0, 10'(OFS_CHIP_CTL), 8'h00, 4'h0, q);
    chk(q, {6'h0, ~config_boot_bit, 1'b0});
    bus(1'b0, 10'(OFS_BROWNOUT), 8'h00, 4'h0, q);
    chk(q & 8'hD0, config_word_two & 8'hD0);
    for (int o = 8'h80; o < 8'h9A; o++) begin
      if (mapped(8'(o))) begin
        bus(1'b0, 10'(o), 8'h00, 4'h0, q);
        chk(q, 8'(spec(8'(o)) >> 8));
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0]  q, w, e, fs, cs;
    logic [15:0] sp;
    void'($urandom(32'h9416));
    do_reset(1'b1, 16);
    chk_por();
    // Sweep: masked write, ignored write without low byte enable, read back
    for (int o = 8'h80; o < 8'h9F; o++) begin
      if (o != OFS_FLASH_START) begin
        sp = spec(8'(o));
        w = (8'($urandom) & sp[7:0]) | (sp[15:8] & ~sp[7:0]);
        bus(1'b1, 10'(o), w, 4'h1 | 4'($urandom), q);
        bus(1'b1, 10'(o), ~w, 4'hE & 4'($urandom), q);
        bus(1'b0, 10'(o), 8'h00, 4'h0, q);
        chk(q, mapped(8'(o)) ? w : UNMAPPED_READ);
      end
    end
    bus(1'b1, 10'h2A3, 8'h5A, 4'h1, q);
    bus(1'b0, 10'h2A3, 8'h00, 4'h0, q);
    chk(q, UNMAPPED_READ);
    // Bit space of port 0, timer and serial control: write each bit singly, read bits and byte back
    foreach (bases[k]) begin
      e = 8'($urandom);
      for (int i = 0; i < 8; i++) begin
        bus(1'b1, 10'h100 + 10'(bases[k]) + 10'(i), {7'h0, e[i]}, 4'h1, q);
      end
      for (int i = 0; i < 8; i++) begin
        bus(1'b0, 10'h100 + 10'(bases[k]) + 10'(i), 8'h00, 4'h0, q);
        chk({7'h0, q[0]}, {7'h0, e[i]});
      end
      bus(1'b0, 10'(bases[k]), 8'h00, 4'h0, q);
      chk(q, e);
      if (k == 0) chk(port0_out, e);
    end
    // Guarded writes: refused without unlock, taken inside the window
    cs = {6'h0, ~config_boot_bit, 1'b0};
    fs = 8'($urandom);
    bus(1'b1, 10'(OFS_CHIP_CTL), 8'h21, 4'h1, q);
    bus(1'b1, 10'(OFS_FLASH_START), ~config_flash_start_byte, 4'h1, q);
    bus(1'b0, 10'(OFS_CHIP_CTL), 8'h00, 4'h0, q);
    chk(q, cs);
    chk(flash_start_out, config_flash_start_byte);
    unlock();
    chk(timed_access, 1'b1);
    bus(1'b1, 10'(OFS_CHIP_CTL), 8'h21 | cs, 4'h1, q);
    chk(chip_out, 8'h21 | cs);
    chk(timed_access, 1'b0);
    unlock();
    bus(1'b1, 10'(OFS_FLASH_START), fs, 4'h1, q);
    chk(flash_start_out, fs);
    // Warm resets with new configuration: kept bits stay, others reload
    bus(1'b1, 10'(OFS_POWER), 8'hC3, 4'h1, q);
    config_word_two <= 8'($urandom);
    config_watchdog_bit <= 1'($urandom);
    config_boot_bit <= 1'($urandom);
    config_flash_start_byte <= 8'($urandom);
    do_reset(1'b0, 3);
    bus(1'b0, 10'(OFS_POWER), 8'h00, 4'h0, q);
    chk(q, 8'h00);
    chk(brownout_enable, 1'b1);
    chk(brownout_flag, 1'b1);
    chk(watchdog_enable_bit, 1'b1);
    chk(flash_start_out, fs);
    bus(1'b0, 10'(OFS_CHIP_CTL), 8'h00, 4'h0, q);
    chk(q, cs);
    bus(1'b0, 10'(OFS_STACK), 8'h00, 4'h0, q);
    chk(q, RST_STACK);
    bus(1'b1, 10'(OFS_POWER), 8'h13, 4'h1, q);
    do_reset(1'b0, 2);
    chk(power_out, 8'h10);
    do_reset(1'b1, 2);
    chk_por();
    summarize();
  end
endmodule // tb_top
`default_nettype wire

//--- verilog/sfr_bank.sv
// Special-function register bank 80H..9FH behind an Avalon-MM slave
// Function
// - Brownout config bits load only at power-on
// - Brownout flag set at power-on when enabled
// - Watchdog, boot select take inverted config
// - Chip control, flash start need timed access
// - Unchanged bits survive all but power-on
// - Power control: power-on 10H, else keep flag
// - Config-marked bits come from config word
// - Flash start byte from config at power-on
// - Ports, timer, serial control bit-addressable
`timescale 1ns/1ps
`default_nettype none
module sfr_bank
  import sfr_bank_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic       por,
  input  wire logic [7:0] config_word_two,
  input  wire logic       config_watchdog_bit,
  input  wire logic       config_boot_bit,
  input  wire logic [7:0] config_flash_start_byte,
  input  wire logic [9:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0] avs_byteenable,
  output logic [31:0]     avs_readdata,
  output logic            avs_waitrequest,
  output logic [7:0]      port0_out,
  output logic [7:0]      power_out,
  output logic [7:0]      chip_out,
  output logic [7:0]      flash_start_out,
  output logic            brownout_enable,
  output logic            brownout_flag,
  output logic            watchdog_enable_bit,
  output logic            timed_access
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [7:0] port0_latch_q, stack_pointer_q, data_pointer_low_q, data_pointer_high_q;
  logic [7:0] power_control_q, timer_control_q, timer_mode_q;
  logic [7:0] timer0_low_count_q, timer1_low_count_q, timer0_high_count_q, timer1_high_count_q;
  logic [7:0] timer_clock_select_q, port1_latch_q;
  logic [7:0] capture_enable_flags_q, capture_edge_select_q, capture_filter_enable_q;
  logic [7:0] cpu_clock_divider_q, port3_output_mode_a_q, port3_output_mode_b_q;
  logic [7:0] serial_control_q, serial_buffer_q;
  logic [7:0] data_flash_start_high_q;  // Kept across non-power-on resets
  logic [7:0] chip_control_q;           // Boot select bit is config loaded
  logic [7:0] brownout_q;               // Brownout control word
  logic       watchdog_q;               // Watchdog enable
  bus_state_t state_q;                  // Bus handshake state
  logic [1:0] ta_stage_q;               // Unlock sequence progress
  logic [2:0] ta_count_q;               // Open window countdown
  logic       ta_open_q;                // Protected write window open
  logic [31:0] rdata_q;                 // Registered read data

  ////////////////////////////////////////////////////////////////////////////
  // Access decode
  logic       is_bit;                   // Bit space at byte addr 400H+
  logic [7:0] ofs;                      // Byte offset or bit address
  logic       wr_go, rd_go;             // Access accepted this cycle
  logic       lane0;                    // Low byte lane enabled
  logic [7:0] wd;                       // Write byte

  assign is_bit = avs_address[9:8] == 2'b01;
  assign ofs    = avs_address[7:0];
  assign lane0  = avs_byteenable[0];
  assign wd     = avs_writedata[7:0];
  // Writes land at the edge that ends the answer cycle
  assign wr_go  = (state_q == ST_ACK) && avs_write && lane0;
  assign rd_go  = (state_q == ST_IDLE) && avs_read;

  // Merge a written byte into a register honouring reserved bits
  function automatic logic [7:0] merge(input logic [7:0] cur, input logic [7:0] nv,
                                       input logic [7:0] mask);
    merge = (cur & ~mask) | (nv & mask);
  endfunction

  // Byte-write hit for one offset
  // Upper ranges must not alias the bank
  function automatic logic hit(input logic [7:0] a);
    hit = wr_go && (avs_address[9:8] == 2'b00) && (ofs == a);
  endfunction

  // Single bit write at a bit-addressable base
  function automatic logic [7:0] bitwr(input logic [7:0] cur, input logic [7:0] base);
    logic [7:0] r;
    r = cur;
    if (wr_go && is_bit && (ofs[7:3] == base[7:3])) begin
      r[ofs[2:0]] = wd[0];
    end
    bitwr = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, answer in ST_ACK
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (avs_read || avs_write) state_q <= ST_ACK;
        ST_ACK:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Waitrequest low only in the answer cycle
  always_ff @(posedge clk_sys) begin
    if (srst) avs_waitrequest <= 1'b1;
    else      avs_waitrequest <= !(state_q == ST_IDLE && (avs_read || avs_write));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timed access: two keys open a short write window
  // Window closes after a chip control or flash start write so each needs a fresh unlock; brownout writes leave it open
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ta_stage_q <= 2'd0;
      ta_count_q <= 3'd0;
      ta_open_q  <= 1'b0;
    end else if (hit(OFS_TA_UNLOCK)) begin
      if (wd == TA_KEY_FIRST) begin
        ta_stage_q <= 2'd1;
        ta_count_q <= TA_WINDOW;
        ta_open_q  <= 1'b0;
      end else if (wd == TA_KEY_SECOND && ta_stage_q == 2'd1 && ta_count_q != 3'd0) begin
        ta_stage_q <= 2'd2;
        ta_count_q <= TA_WINDOW;
        ta_open_q  <= 1'b1;
      end else begin
        ta_stage_q <= 2'd0;
        ta_count_q <= 3'd0;
        ta_open_q  <= 1'b0;
      end

    end else if (hit(OFS_CHIP_CTL) || hit(OFS_FLASH_START)) begin
      ta_stage_q <= 2'd0;
      ta_count_q <= 3'd0;
      ta_open_q  <= 1'b0;

    end else if (ta_count_q != 3'd0) begin
      ta_count_q <= ta_count_q - 3'd1;
      ta_open_q  <= (ta_stage_q == 2'd2) && (ta_count_q != 3'd1);
    end else begin
      ta_stage_q <= 2'd0;
      ta_open_q  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Plain registers: on any reset ports load FFH, stack 07H, the rest are cleared
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      port0_latch_q           <= RST_PORT;
      stack_pointer_q         <= RST_STACK;
      data_pointer_low_q      <= RST_ZERO;
      data_pointer_high_q     <= RST_ZERO;
      timer_control_q         <= RST_ZERO;
      timer_mode_q            <= RST_ZERO;
      timer0_low_count_q      <= RST_ZERO;
      timer1_low_count_q      <= RST_ZERO;
      timer0_high_count_q     <= RST_ZERO;
      timer1_high_count_q     <= RST_ZERO;
      timer_clock_select_q    <= RST_ZERO;
      port1_latch_q           <= RST_PORT;
      capture_enable_flags_q  <= RST_ZERO;
      capture_edge_select_q   <= RST_ZERO;
      capture_filter_enable_q <= RST_ZERO;
      cpu_clock_divider_q     <= RST_ZERO;
      port3_output_mode_a_q   <= RST_ZERO;
      port3_output_mode_b_q   <= RST_ZERO;
      serial_control_q        <= RST_ZERO;
      serial_buffer_q         <= RST_ZERO;
    end else begin
      // Byte writes; reserved bits stay at reset value
      if (hit(OFS_PORT0))      port0_latch_q <= wd;
      else                     port0_latch_q <= bitwr(port0_latch_q, BIT_BASE_PORT0);
      if (hit(OFS_STACK))      stack_pointer_q <= wd;
      if (hit(OFS_DPTR_LO))    data_pointer_low_q <= wd;
      if (hit(OFS_DPTR_HI))    data_pointer_high_q <= wd;

      // Timers
      if (hit(OFS_TIMER_CTL))  timer_control_q <= wd;
      else                     timer_control_q <= bitwr(timer_control_q, BIT_BASE_TCTL);
      if (hit(OFS_TIMER_MODE)) timer_mode_q <= wd;
      if (hit(OFS_T0_LO))      timer0_low_count_q <= wd;
      if (hit(OFS_T1_LO))      timer1_low_count_q <= wd;
      if (hit(OFS_T0_HI))      timer0_high_count_q <= wd;
      if (hit(OFS_T1_HI))      timer1_high_count_q <= wd;

      if (hit(OFS_TCLK_SEL))   timer_clock_select_q <= merge(timer_clock_select_q, wd, MASK_TCLK);

      // Port 1
      if (hit(OFS_PORT1))      port1_latch_q <= merge(port1_latch_q, wd, MASK_PORT1);
      else                     port1_latch_q <= merge(port1_latch_q,
                                 bitwr(port1_latch_q, BIT_BASE_PORT1), MASK_PORT1);

      if (hit(OFS_CAP_EN))     capture_enable_flags_q <= merge(capture_enable_flags_q, wd, MASK_CAP_EN);
      if (hit(OFS_CAP_EDGE))   capture_edge_select_q <= merge(capture_edge_select_q, wd, MASK_CAP_EDGE);
      if (hit(OFS_CAP_FILT))   capture_filter_enable_q <= merge(capture_filter_enable_q, wd, MASK_CAP_FILT);
      if (hit(OFS_CLK_DIV))    cpu_clock_divider_q <= wd;
      if (hit(OFS_P3_MODE_A))  port3_output_mode_a_q <= wd;
      if (hit(OFS_P3_MODE_B))  port3_output_mode_b_q <= merge(port3_output_mode_b_q, wd, MASK_P3_B);

      // Serial port
      if (hit(OFS_SER_CTL))    serial_control_q <= wd;
      else                     serial_control_q <= bitwr(serial_control_q, BIT_BASE_SCTL);
      if (hit(OFS_SER_BUF))    serial_buffer_q <= wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power control: power-off flag kept on non-power-on reset
  always_ff @(posedge clk_sys) begin
    if (srst && por) begin
      power_control_q <= RST_POWER_POR;
    end else if (srst) begin
      power_control_q <= RST_ZERO | (power_control_q & (8'h01 << POWER_OFF_BIT));
    end else if (hit(OFS_POWER)) begin
      power_control_q <= merge(power_control_q, wd, MASK_POWER);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brownout and watchdog: config loaded only at power-on
  always_ff @(posedge clk_sys) begin
    if (srst && por) begin
      brownout_q                <= RST_ZERO;
      brownout_q[BO_ENABLE_BIT] <= config_word_two[BO_ENABLE_BIT];
      brownout_q[BO_LEVEL_BIT]  <= config_word_two[BO_LEVEL_BIT];
      brownout_q[BO_RESET_BIT]  <= config_word_two[BO_RESET_BIT];
      brownout_q[BO_FLAG_BIT]   <= config_word_two[BO_ENABLE_BIT];
      watchdog_q                <= ~config_watchdog_bit;
    end else if (srst) begin
      // Whole word kept across other resets
      brownout_q <= brownout_q;
    end else if (hit(OFS_BROWNOUT) && ta_open_q) begin
      brownout_q <= merge(brownout_q, wd, MASK_BROWNOUT);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Chip control and flash start: timed-access writes only
  always_ff @(posedge clk_sys) begin
    if (srst && por) begin
      chip_control_q               <= RST_ZERO;
      chip_control_q[BOOT_SEL_BIT] <= ~config_boot_bit;
      data_flash_start_high_q      <= config_flash_start_byte;
    end else if (srst) begin
      // Boot select bit kept
      chip_control_q[7:2]     <= RST_ZERO[7:2];
      chip_control_q[0]       <= RST_ZERO[0];
      data_flash_start_high_q <= data_flash_start_high_q;
    end else begin
      if (hit(OFS_CHIP_CTL) && ta_open_q) begin
        chip_control_q <= merge(chip_control_q, wd, MASK_CHIP);
      end

      if (hit(OFS_FLASH_START) && ta_open_q) begin
        data_flash_start_high_q <= wd;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets return a fixed value
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    unique case (a)
      OFS_PORT0:       rd_byte = port0_latch_q;
      OFS_STACK:       rd_byte = stack_pointer_q;
      OFS_DPTR_LO:     rd_byte = data_pointer_low_q;
      OFS_DPTR_HI:     rd_byte = data_pointer_high_q;
      OFS_POWER:       rd_byte = power_control_q;
      OFS_TIMER_CTL:   rd_byte = timer_control_q;
      OFS_TIMER_MODE:  rd_byte = timer_mode_q;
      OFS_T0_LO:       rd_byte = timer0_low_count_q;
      OFS_T1_LO:       rd_byte = timer1_low_count_q;
      OFS_T0_HI:       rd_byte = timer0_high_count_q;
      OFS_T1_HI:       rd_byte = timer1_high_count_q;
      OFS_TCLK_SEL:    rd_byte = timer_clock_select_q;
      OFS_PORT1:       rd_byte = port1_latch_q;
      OFS_CAP_EN:      rd_byte = capture_enable_flags_q;
      OFS_CAP_EDGE:    rd_byte = capture_edge_select_q;
      OFS_CAP_FILT:    rd_byte = capture_filter_enable_q;
      OFS_CLK_DIV:     rd_byte = cpu_clock_divider_q;
      OFS_P3_MODE_A:   rd_byte = port3_output_mode_a_q;
      OFS_P3_MODE_B:   rd_byte = port3_output_mode_b_q;
      OFS_SER_CTL:     rd_byte = serial_control_q;
      OFS_SER_BUF:     rd_byte = serial_buffer_q;
      OFS_FLASH_START: rd_byte = data_flash_start_high_q;
      OFS_CHIP_CTL:    rd_byte = chip_control_q;
      // Own additions past the byte map
      OFS_BROWNOUT:    rd_byte = brownout_q;
      OFS_TA_UNLOCK:   rd_byte = {6'h00, ta_stage_q};
      default:         rd_byte = UNMAPPED_READ;
    endcase
  endfunction

  logic [7:0] bit_src;                  // Byte holding addressed bit
  always_comb begin
    unique case (ofs[7:3])
      BIT_BASE_PORT0[7:3]: bit_src = port0_latch_q;
      BIT_BASE_TCTL[7:3]:  bit_src = timer_control_q;
      BIT_BASE_PORT1[7:3]: bit_src = port1_latch_q;
      BIT_BASE_SCTL[7:3]:  bit_src = serial_control_q;
      default:             bit_src = UNMAPPED_READ;
    endcase
  end

  // Read data captured at acceptance, stands during answer cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_go) begin
      if (avs_address[9])  rdata_q <= 32'h0000_0000;
      else if (is_bit)     rdata_q <= {31'h0000_0000, bit_src[ofs[2:0]]};
      else                 rdata_q <= {24'h00_0000, rd_byte(ofs)};
    end
  end
  assign avs_readdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs straight from flip-flops
  assign port0_out           = port0_latch_q;
  assign power_out           = power_control_q;
  assign chip_out            = chip_control_q;
  assign flash_start_out     = data_flash_start_high_q;
  assign brownout_enable     = brownout_q[BO_ENABLE_BIT];
  assign brownout_flag       = brownout_q[BO_FLAG_BIT];
  assign watchdog_enable_bit = watchdog_q;
  // Window flag is a flop as well
  assign timed_access        = ta_open_q;

endmodule : sfr_bank
`default_nettype wire

//--- verilog/sfr_bank_pkg.sv
// Package: register map, field positions and reset values for the register bank
package sfr_bank_pkg;
  // Byte offsets of the bank; bus byte address is four times the offset
  localparam logic [7:0] OFS_PORT0       = 8'h80;
  localparam logic [7:0] OFS_STACK       = 8'h81;
  localparam logic [7:0] OFS_DPTR_LO     = 8'h82;
  localparam logic [7:0] OFS_DPTR_HI     = 8'h83;
  localparam logic [7:0] OFS_POWER       = 8'h87;
  localparam logic [7:0] OFS_TIMER_CTL   = 8'h88;
  localparam logic [7:0] OFS_TIMER_MODE  = 8'h89;
  localparam logic [7:0] OFS_T0_LO       = 8'h8A;
  localparam logic [7:0] OFS_T1_LO       = 8'h8B;
  localparam logic [7:0] OFS_T0_HI       = 8'h8C;
  localparam logic [7:0] OFS_T1_HI       = 8'h8D;
  localparam logic [7:0] OFS_TCLK_SEL    = 8'h8E;
  localparam logic [7:0] OFS_PORT1       = 8'h90;
  localparam logic [7:0] OFS_CAP_EN      = 8'h92;
  localparam logic [7:0] OFS_CAP_EDGE    = 8'h93;
  localparam logic [7:0] OFS_CAP_FILT    = 8'h94;
  localparam logic [7:0] OFS_CLK_DIV     = 8'h95;
  localparam logic [7:0] OFS_P3_MODE_A   = 8'h96;
  localparam logic [7:0] OFS_P3_MODE_B   = 8'h97;
  localparam logic [7:0] OFS_SER_CTL     = 8'h98;
  localparam logic [7:0] OFS_SER_BUF     = 8'h99;
  localparam logic [7:0] OFS_FLASH_START = 8'h9C;
  localparam logic [7:0] OFS_CHIP_CTL    = 8'h9F;
  // Own choices: timed-access unlock and brownout control word
  localparam logic [7:0] OFS_TA_UNLOCK   = 8'hC7;
  localparam logic [7:0] OFS_BROWNOUT    = 8'hA3;
  localparam logic [7:0] TA_KEY_FIRST    = 8'hAA;
  localparam logic [7:0] TA_KEY_SECOND   = 8'h55;
  localparam logic [2:0] TA_WINDOW       = 3'h4;
  // Bit-address spaces of bit-addressable registers
  localparam logic [7:0] BIT_BASE_PORT0  = 8'h80;
  localparam logic [7:0] BIT_BASE_TCTL   = 8'h88;
  localparam logic [7:0] BIT_BASE_PORT1  = 8'h90;
  localparam logic [7:0] BIT_BASE_SCTL   = 8'h98;
  // Reset values
  localparam logic [7:0] RST_PORT        = 8'hFF;
  localparam logic [7:0] RST_STACK       = 8'h07;
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_POWER_POR   = 8'h10;
  localparam logic [7:0] UNMAPPED_READ   = 8'h00;
  // Field positions
  localparam int POWER_OFF_BIT      = 4;
  localparam int BOOT_SEL_BIT       = 1;
  localparam int BO_ENABLE_BIT      = 7;
  localparam int BO_LEVEL_BIT       = 6;
  localparam int BO_RESET_BIT       = 4;
  localparam int BO_FLAG_BIT        = 3;
  localparam int WDOG_ENABLE_BIT    = 0;
  // Writable masks; reserved bits hold their reset value
  localparam logic [7:0] MASK_POWER    = 8'hDF;
  localparam logic [7:0] MASK_PORT1    = 8'hDF;
  localparam logic [7:0] MASK_TCLK     = 8'h18;
  localparam logic [7:0] MASK_CAP_EN   = 8'h77;
  localparam logic [7:0] MASK_CAP_EDGE = 8'h3F;
  localparam logic [7:0] MASK_CAP_FILT = 8'h70;
  localparam logic [7:0] MASK_P3_B     = 8'h07;
  localparam logic [7:0] MASK_CHIP     = 8'hE3;
  localparam logic [7:0] MASK_BROWNOUT = 8'hD9;
  // Bus access states
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ACK = 2'b01} bus_state_t;
endpackage : sfr_bank_pkg
